/* File: verification/drive_monitor_assertions.sv */
`timescale 1ns/1ps
module drive_monitor_assertions
  import drive_monitor_pkg::*;
#(
  parameter longint GATE_CYCLES = GATE_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hostRdEn,
  input wire logic [15:0] hostAddr,
  input wire logic [15:0] hostRdData,
  input wire logic hostRdValid,
  input wire logic hostAddrErr,
  input wire logic signed [15:0] runFreqRaw,
  input wire logic [9:0] digitalInputs,
  input wire logic [4:0] virtualInputs,
  input wire logic fastOutput,
  input wire logic [1:0] relayOutputs,
  input wire logic [1:0] digitalOutputs,
  input wire logic [4:0] virtualOutputs,
  input wire logic [15:0] analogTwoVolts,
  input wire logic [15:0] analogTwoMilliamps,
  input wire logic analogTwoUnitSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] calmCnt_r;
  logic [16:0] freqMag;
  logic [15:0] freqWord;
  logic inWin;
  logic [41:0] watch;
  // sources watched for rest, magnitude and window decode
  assign watch = {runFreqRaw, virtualInputs, digitalInputs, virtualOutputs, digitalOutputs,
                  relayOutputs, fastOutput, analogTwoUnitSelect};
  assign freqMag = runFreqRaw[15] ? 17'h00000 - {1'b1, runFreqRaw} : {1'b0, runFreqRaw};
  assign freqWord = (freqMag > {1'b0, FREQ_MAX}) ? FREQ_MAX : freqMag[15:0];
  assign inWin = (hostAddr >= MON_BASE) && (hostAddr <= MON_LAST);
  // word checks only after inputs rested, so register latency cannot race them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calmCnt_r <= 2'h0;
    end else if ($changed(watch) || $changed(analogTwoVolts) || $changed(analogTwoMilliamps)) begin
      calmCnt_r <= 2'h0;
    end else if (calmCnt_r != 2'h3) begin
      calmCnt_r <= calmCnt_r + 2'h1;
    end
  end
  a_read_answer: assert property (hostRdEn |=> hostRdValid)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (!hostRdEn |=> !hostRdValid && !hostAddrErr)
    else $error("answer without a read");
  a_outside_error: assert property (hostRdEn && !inWin |=> hostAddrErr && hostRdData == 16'h0000)
    else $error("outside read not refused");
  a_inside_clean: assert property (hostRdEn && inWin |=> !hostAddrErr)
    else $error("window read flagged");
  a_data_holds: assert property (!hostRdValid |-> $stable(hostRdData))
    else $error("read data moved without a read");
  a_input_word: assert property (calmCnt_r == 2'h3 && hostRdEn &&
    hostAddr == 16'h7007 |=>
    hostRdData == {1'b0, $past(virtualInputs), $past(digitalInputs)})
    else $error("input word wrong");
  a_output_word: assert property (calmCnt_r == 2'h3 && hostRdEn &&
    hostAddr == 16'h7008 |=>
    hostRdData == {6'h00, $past(virtualOutputs), $past(digitalOutputs),
    $past(relayOutputs), $past(fastOutput)})
    else $error("output word wrong");
  a_analog_unit: assert property (calmCnt_r == 2'h3 && hostRdEn &&
    hostAddr == 16'h700A |=>
    hostRdData == ($past(analogTwoUnitSelect) ? $past(analogTwoMilliamps)
    : $past(analogTwoVolts)))
    else $error("analog unit wrong");
  a_freq_magnitude: assert property (calmCnt_r == 2'h3 && hostRdEn &&
    hostAddr == 16'h7000 |=>
    hostRdData == $past(freqWord))
    else $error("frequency magnitude wrong");
endmodule : drive_monitor_assertions

bind drive_monitor_readout_bank drive_monitor_assertions #(.GATE_CYCLES(GATE_CYCLES))
  i_drive_monitor_assertions (.clk, .reset_n, .hostRdEn, .hostAddr, .hostRdData,
  .hostRdValid, .hostAddrErr, .runFreqRaw, .digitalInputs, .virtualInputs, .fastOutput,
  .relayOutputs, .digitalOutputs, .virtualOutputs, .analogTwoVolts, .analogTwoMilliamps,
  .analogTwoUnitSelect);

/* File: verification/drive_monitor_readout_bank_tb.sv */
`timescale 1ns/1ps
module drive_monitor_readout_bank_tb;
  import drive_monitor_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hostRdEn, hostWrEn, hostRdValid, hostAddrErr;
  logic [15:0] hostAddr, hostWrData, hostRdData;
  logic signed [15:0] runFreqRaw = 16'h0000, setFreqRaw, analogThreeRaw;
  logic signed [16:0] feedbackSpeedRaw = 17'h00000, encoderSpeedRaw;
  logic [9:0] digitalInputs = 10'h000;
  logic [4:0] virtualInputs = 5'h00, virtualOutputs = 5'h00;
  logic [1:0] relayOutputs = 2'h0, digitalOutputs = 2'h0, phase = 2'h0, quadIdx = 2'h0;
  logic fastOutput = 1'b0, analogTwoUnitSelect = 1'b0, runTimerActive = 1'b0, pulseOn = 1'b0;
  logic fastPulseInput, encoderPhaseA, encoderPhaseB;
  logic [15:0] analogTwoVolts = 16'h0000, analogTwoMilliamps = 16'h0000;
  logic [15:0] speedDisplayDecimals = 16'h0000, runTimeLeft = 16'h0000, pulsesPerMeter = 16'h0003;
  logic [15:0] busVoltage, outputVoltage, outputCurrent, outputPower, outputTorque, loadSpeed;
  logic [15:0] loopSetpoint, loopFeedback, analogOneRaw, analogTwoRaw, mainFrequency;
  logic [15:0] auxiliaryFrequency, motorTemperature, targetTorque, angleSensorPosition;
  logic [15:0] powerFactorAngle;
  logic [287:0] passVec = '0;
  logic [7:0] passOfs [17] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0E, 8'h0F, 8'h10, 8'h15,
                               8'h16, 8'h17, 8'h1E, 8'h1F, 8'h22, 8'h23, 8'h24, 8'h25};
  logic [31:0] seed = 32'h00000041;
  logic [31:0] r;
  int nMismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // passed-through words come from one random vector, lowest word at the first offset
  assign {powerFactorAngle, angleSensorPosition, targetTorque, motorTemperature,
          auxiliaryFrequency, mainFrequency, analogThreeRaw, analogTwoRaw, analogOneRaw,
          loopFeedback, loopSetpoint, loadSpeed, outputTorque, outputPower, outputCurrent,
          outputVoltage, busVoltage} = passVec[271:0];
  assign setFreqRaw = 16'h0000 - runFreqRaw; // opposite sign, same magnitude
  assign encoderSpeedRaw = feedbackSpeedRaw;
  assign {encoderPhaseA, encoderPhaseB} = {quadIdx[1], quadIdx[1] ^ quadIdx[0]};
  assign fastPulseInput = pulseOn & phase[1]; // 4-cycle period gives a whole count per gate
  drive_monitor_readout_bank #(.GATE_CYCLES(100)) i_drive_monitor_readout_bank (.*);
  host_model i_host_model (.*);
  // clock, pulse phase and hang guard
  always #2.5 clk = ~clk;
  always @(negedge clk) phase <= phase + 2'h1;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    int m;
    m = (v < 0) ? -int'(v) : int'(v);
    return (m > int'(FREQ_MAX)) ? FREQ_MAX : 16'(m);
  endfunction : mag
  function automatic logic [15:0] spd(input logic signed [16:0] v, input logic [15:0] dec);
    int s;
    s = int'(v);
    if ((dec / 10) % 10 == 1) return 16'(s / 10);
    return 16'((s > int'(SPEED2_MAX)) ? int'(SPEED2_MAX) : (s < -int'(SPEED2_MAX))
      ? -int'(SPEED2_MAX) : s);
  endfunction : spd
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic look(input logic [15:0] a, input logic [15:0] d, input logic err);
    logic [17:0] ans;
    i_host_model.rd(a, ans);
    chk(ans, {1'b1, err, d});
  endtask : look
  task automatic step(input logic up);
    repeat (2) @(negedge clk);
    quadIdx = up ? quadIdx + 2'h1 : quadIdx - 2'h1;
  endtask : step
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // main sequence: window edges, random words, host mirror, encoder, pulse input
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    look(16'h6FFF, 16'h0000, 1'b1);
    look(16'h7045, 16'h0000, 1'b1);
    look(16'h7009, 16'h0000, 1'b0);
    for (int i = 0; i < 24; i++) begin
      r = xs();
      {virtualInputs, digitalInputs} = r[14:0];
      {virtualOutputs, digitalOutputs, relayOutputs, fastOutput} = r[24:15];
      {analogTwoUnitSelect, runTimerActive} = r[26:25];
      {analogTwoMilliamps, analogTwoVolts} = xs();
      r = xs();
      runFreqRaw = (i == 0) ? 16'h8000 : r[15:0];
      runTimeLeft = (i == 1) ? 16'hFFFF : r[31:16];
      r = xs();
      feedbackSpeedRaw = (i == 2) ? 17'h1FFFF : (i == 3) ? 17'h0F000 : r[16:0];
      speedDisplayDecimals = (i % 2 == 0) ? 16'h0070 : 16'h0014;
      for (int k = 0; k < 9; k++) passVec[32*k +: 32] = xs();
      repeat (4) @(negedge clk);
      look(16'h7007, {1'b0, virtualInputs, digitalInputs}, 1'b0);
      look(16'h7008, {6'h00, virtualOutputs, digitalOutputs, relayOutputs, fastOutput}, 1'b0);
      look(16'h700A, analogTwoUnitSelect ? analogTwoMilliamps : analogTwoVolts, 1'b0);
      look(16'h7000, mag(runFreqRaw), 1'b0);
      look(16'h7001, mag(runFreqRaw), 1'b0);
      look(16'h7013, spd(feedbackSpeedRaw, speedDisplayDecimals), 1'b0);
      look(16'h701D, spd(feedbackSpeedRaw, speedDisplayDecimals), 1'b0);
      look(16'h7014, !runTimerActive ? 16'h0000 : (runTimeLeft > RUN_LEFT_MAX) ? RUN_LEFT_MAX
        : runTimeLeft, 1'b0);
      for (int k = 0; k < 17; k++) look({8'h70, passOfs[k]}, passVec[16*k +: 16], 1'b0);
    end
    i_host_model.wr(16'h1000, 16'h7FFF);
    look(16'h701C, 16'h2710, 1'b0);
    i_host_model.wr(16'h1001, 16'h0005);
    look(16'h701C, 16'h2710, 1'b0);
    i_host_model.wr(16'h1000, 16'hFF9C);
    look(16'h701C, 16'hFF9C, 1'b0);
    for (int k = 0; k < 3; k++) step(1'b0);
    repeat (4) @(negedge clk);
    look(16'h7026, 16'hFFFD, 1'b0);
    for (int k = 0; k < 8; k++) step(1'b1);
    repeat (4) @(negedge clk);
    look(16'h7026, 16'h0005, 1'b0);
    look(16'h7026, 16'h0005, 1'b0);
    pulseOn = 1'b1;
    repeat (320) @(negedge clk);
    look(16'h701B, 16'h0019, 1'b0);
    look(16'h7012, 16'h0002, 1'b0);
    look(16'h7018, 16'h01F4, 1'b0);
    pulsesPerMeter = 16'h0000;
    repeat (230) @(negedge clk);
    look(16'h7018, 16'h0000, 1'b0);
    wrap_up();
  end
endmodule : drive_monitor_readout_bank_tb

/* File: verification/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic [15:0] hostRdData,
  input wire logic hostRdValid,
  input wire logic hostAddrErr,
  output logic hostRdEn,
  output logic hostWrEn,
  output logic [15:0] hostAddr,
  output logic [15:0] hostWrData
);
  // quiet bus at time zero
  initial begin
    hostRdEn = 1'b0;
    hostWrEn = 1'b0;
    hostAddr = 16'h0000;
    hostWrData = 16'h0000;
  end
  // one taking edge per read; answer picked up in the low phase after it
  task automatic rd(input logic [15:0] a, output logic [17:0] ans);
    @(negedge clk);
    hostAddr = a;
    hostRdEn = 1'b1;
    @(negedge clk);
    ans = {hostRdValid, hostAddrErr, hostRdData};
    hostRdEn = 1'b0;
    hostAddr = ~a; // released lines never keep the last value
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {hostAddr, hostWrData, hostWrEn} = {a, d, 1'b1};
    @(negedge clk);
    hostWrEn = 1'b0;
    hostWrData = ~d;
    hostAddr = ~a;
  endtask : wr
endmodule : host_model

/* File: verilog/drive_monitor_pkg.sv */
package drive_monitor_pkg;
  // host address window of the monitoring bank
  localparam logic [15:0] MON_BASE = 16'h7000;
  localparam logic [15:0] MON_LAST = 16'h7044;
  localparam int MON_WORDS = 69;
  localparam int IDX_W = 7;
  // host write address mirrored by the setting monitor
  localparam logic [15:0] HOST_SET_ADDR = 16'h1000;
  localparam logic [15:0] MON_RESET = 16'h0000;

  // word offsets inside the window
  localparam int OFS_RUN_FREQ = 0;
  localparam int OFS_SET_FREQ = 1;
  localparam int OFS_BUS_VOLT = 2;
  localparam int OFS_OUT_VOLT = 3;
  localparam int OFS_OUT_CURR = 4;
  localparam int OFS_OUT_POWER = 5;
  localparam int OFS_OUT_TORQUE = 6;
  localparam int OFS_IN_BITMAP = 7;
  localparam int OFS_OUT_BITMAP = 8;
  localparam int OFS_AN2_READING = 10;
  localparam int OFS_LOAD_SPEED = 14;
  localparam int OFS_LOOP_SET = 15;
  localparam int OFS_LOOP_FB = 16;
  localparam int OFS_PULSE_KHZ = 18;
  localparam int OFS_FB_SPEED = 19;
  localparam int OFS_RUN_LEFT = 20;
  localparam int OFS_AN1_RAW = 21;
  localparam int OFS_AN2_RAW = 22;
  localparam int OFS_AN3_RAW = 23;
  localparam int OFS_LIN_SPEED = 24;
  localparam int OFS_PULSE_HZ = 27;
  localparam int OFS_HOST_MIRROR = 28;
  localparam int OFS_ENC_SPEED = 29;
  localparam int OFS_MAIN_FREQ = 30;
  localparam int OFS_AUX_FREQ = 31;
  localparam int OFS_MOTOR_TEMP = 34;
  localparam int OFS_TARGET_TORQUE = 35;
  localparam int OFS_ANGLE_POS = 36;
  localparam int OFS_PF_ANGLE = 37;
  localparam int OFS_QUAD_POS = 38;

  // value limits, in the units of each word
  localparam logic [15:0] FREQ_MAX = 16'hC350;
  localparam logic [15:0] RUN_LEFT_MAX = 16'hFDE8;
  localparam logic [15:0] KHZ_MAX = 16'h2710;
  localparam logic [15:0] U16_MAX = 16'hFFFF;
  localparam logic signed [16:0] SPEED2_MAX = 17'sh07D00;
  localparam logic signed [15:0] PCT_MAX = 16'sh2710;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam int HZ_PER_KHZ_STEP = 10;
  localparam int SEC_PER_MIN = 60;

  // pulse measurement gate
  localparam longint CLK_HZ = 200000000;
  localparam longint GATE_MS = 1000;
  localparam longint GATE_CYCLES_DEF = CLK_HZ * GATE_MS / 1000;
  localparam int GATE_W = 28;
  localparam int PCNT_W = 17;
  localparam int DVD_W = 24;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_LOAD = 2'b01,
    DIV_RUN = 2'b11,
    DIV_DONE = 2'b10
  } div_state_type;
endpackage : drive_monitor_pkg

/* File: verilog/drive_monitor_readout_bank.sv */
// What this block does
// - every monitoring value is readable by the host at 0x7000 to 0x7044
// - input word: bits 0 to 9 are inputs one to ten, 1 means high
// - output word: fast output, relays, outputs one-two, virtual outputs, 1 means high
// - second analog reading in volts when unit select is 0, milliamps when 1
// - pulse frequency in 0.01 kHz steps, range 0 to 100 kHz
// - same pulse measurement in 1 Hz steps, limited to 65535
// - tens digit of display setting picks two or one decimals for speeds
// - remaining run time in 0.1 min while timer runs, at most 6500.0
// - setting monitor mirrors last host write to 0x1000, within plus/minus 100.00 percent
// - encoder position counts four per encoder line
// - position counts up forward, down reverse, wrapping at 65535 and 0
// - linear speed is pulses per minute divided by pulses per meter
// - running and set frequency show magnitude only, 0 to 500 Hz
// - raw analog readings shown before correction, third input bipolar
`timescale 1ns/1ps
module drive_monitor_readout_bank
  import drive_monitor_pkg::*;
#(
  // pulse measuring gate; shorter gates update faster but resolve fewer hertz
  parameter longint GATE_CYCLES = GATE_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  // host link: reads of the window, writes to the setting address
  input wire logic hostRdEn,
  input wire logic hostWrEn,
  input wire logic [15:0] hostAddr,
  input wire logic [15:0] hostWrData,
  output logic [15:0] hostRdData,
  output logic hostRdValid,
  output logic hostAddrErr,
  // drive quantities from the control side
  input wire logic signed [15:0] runFreqRaw,
  input wire logic signed [15:0] setFreqRaw,
  input wire logic [15:0] busVoltage,
  input wire logic [15:0] outputVoltage,
  input wire logic [15:0] outputCurrent,
  input wire logic [15:0] outputPower,
  input wire logic [15:0] outputTorque,
  // terminal levels, 1 means high
  input wire logic [9:0] digitalInputs,
  input wire logic [4:0] virtualInputs,
  input wire logic fastOutput,
  input wire logic [1:0] relayOutputs,
  input wire logic [1:0] digitalOutputs,
  input wire logic [4:0] virtualOutputs,
  // analog readings, speeds and the settings that scale them
  input wire logic [15:0] analogTwoVolts,
  input wire logic [15:0] analogTwoMilliamps,
  input wire logic analogTwoUnitSelect,
  input wire logic [15:0] loadSpeed,
  input wire logic [15:0] loopSetpoint,
  input wire logic [15:0] loopFeedback,
  input wire logic signed [16:0] feedbackSpeedRaw,
  input wire logic signed [16:0] encoderSpeedRaw,
  input wire logic [15:0] speedDisplayDecimals,
  input wire logic runTimerActive,
  input wire logic [15:0] runTimeLeft,
  input wire logic [15:0] analogOneRaw,
  input wire logic [15:0] analogTwoRaw,
  input wire logic signed [15:0] analogThreeRaw,
  // pulse input and its length scale; the words after it pass straight through
  input wire logic fastPulseInput,
  input wire logic [15:0] pulsesPerMeter,
  input wire logic [15:0] mainFrequency,
  input wire logic [15:0] auxiliaryFrequency,
  input wire logic [15:0] motorTemperature,
  input wire logic [15:0] targetTorque,
  input wire logic [15:0] angleSensorPosition,
  input wire logic [15:0] powerFactorAngle,
  // quadrature encoder phases, counted on every edge
  input wire logic encoderPhaseA,
  input wire logic encoderPhaseB
);

  // magnitude of a signed frequency, held to 500.00 Hz
  function automatic logic [15:0] absClamp(input logic signed [15:0] v);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : 16'(v);
    absClamp = (mag > FREQ_MAX) ? FREQ_MAX : mag;
  endfunction : absClamp

  // tens digit of the speed display setting
  function automatic logic [3:0] tensDigit(input logic [15:0] s);
    logic [15:0] t;
    t = (s / 16'd10) % 16'd10;
    tensDigit = t[3:0];
  endfunction : tensDigit

  // raw speed is in 0.01 Hz; one decimal drops a digit, two decimals clamp to 320.00
  function automatic logic [15:0] scaleSpeed(input logic signed [16:0] raw,
                                             input logic [3:0] digit);
    logic signed [16:0] v;
    v = raw;
    if (digit == DIGIT_ONE) begin
      v = raw / 17'sd10;
    end else if (raw > SPEED2_MAX) begin
      v = SPEED2_MAX;
    end else if (raw < -SPEED2_MAX) begin
      v = -SPEED2_MAX;
    end
    scaleSpeed = v[15:0];
  endfunction : scaleSpeed

  // one stored word per address of the window
  logic [15:0] mon_r [MON_WORDS];
  logic [15:0] monNxt [MON_WORDS];
  logic [15:0] mirror_r;
  logic [15:0] quadPos;
  logic [3:0] speedDigit;
  logic [15:0] inBits;
  logic [15:0] outBits;

  // pulse measurement state
  logic pulsePrev_r;
  logic [GATE_W-1:0] gateCnt_r;
  logic [PCNT_W-1:0] pulseCnt_r;
  logic [PCNT_W-1:0] hzMeas_r;
  logic gateEnd;
  logic pulseEdge;
  logic [15:0] pulseHz;
  logic [15:0] pulseKhz;
  logic [PCNT_W-1:0] khzDiv;

  // linear speed divider state
  div_state_type divState_r;
  logic [4:0] divStep_r;
  logic [DVD_W-1:0] dvd_r;
  logic [16:0] rem_r;
  logic [15:0] dvs_r;
  logic [15:0] linSpeed_r;
  logic [16:0] remShift;
  logic remFits;

  // read decode
  logic inWindow;
  logic [15:0] wordOfs;

  // position counter keeps its own phase history
  quad_position_counter quadCounter (
    .clk(clk),
    .reset_n(reset_n),
    .phaseA(encoderPhaseA),
    .phaseB(encoderPhaseB),
    .position(quadPos)
  );

  // terminal bitmaps; upper input bits carry the virtual inputs
  assign inBits = {1'b0, virtualInputs, digitalInputs};
  assign outBits = {6'h00, virtualOutputs, digitalOutputs, relayOutputs, fastOutput};
  assign speedDigit = tensDigit(speedDisplayDecimals);

  // edge of the fast pulse input, and end of each measuring gate
  // the input is taken as synchronous, so one flop is enough to find its edge
  assign pulseEdge = fastPulseInput & ~pulsePrev_r;
  assign gateEnd = (gateCnt_r == GATE_W'(GATE_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulsePrev_r <= 1'b0;
      gateCnt_r <= '0;
    end else begin
      pulsePrev_r <= fastPulseInput;
      gateCnt_r <= gateEnd ? '0 : gateCnt_r + 1'b1;
    end
  end

  // pulses counted over one gate; the count saturates rather than wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulseCnt_r <= '0;
      hzMeas_r <= '0;
    end else if (gateEnd) begin
      pulseCnt_r <= '0;
      hzMeas_r <= pulseCnt_r + PCNT_W'(pulseEdge && !(&pulseCnt_r));
    end else if (pulseEdge && !(&pulseCnt_r)) begin
      pulseCnt_r <= pulseCnt_r + 1'b1;
    end
  end

  // one measurement feeds both the hertz and kilohertz words
  assign khzDiv = hzMeas_r / PCNT_W'(HZ_PER_KHZ_STEP);
  assign pulseHz = (hzMeas_r > PCNT_W'(U16_MAX)) ? U16_MAX : hzMeas_r[15:0];
  assign pulseKhz = (khzDiv > PCNT_W'(KHZ_MAX)) ? KHZ_MAX : khzDiv[15:0];

  // restoring divider: pulses per minute over pulses per meter
  assign remShift = {rem_r[15:0], dvd_r[DVD_W-1]};
  assign remFits = (remShift >= {1'b0, dvs_r});

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divState_r <= DIV_IDLE;
      divStep_r <= '0;
      dvd_r <= '0;
      rem_r <= '0;
      dvs_r <= '0;
    end else begin
      case (divState_r)
        DIV_IDLE: begin
          if (gateEnd) begin
            // the count of the gate just closed is taken on the next cycle
            divState_r <= DIV_LOAD;
            dvs_r <= pulsesPerMeter;
          end
        end
        DIV_LOAD: begin
          // a saturated count times sixty still fits the dividend
          dvd_r <= DVD_W'(hzMeas_r) * DVD_W'(SEC_PER_MIN);
          rem_r <= '0;
          divStep_r <= '0;
          divState_r <= DIV_RUN;
        end
        DIV_RUN: begin
          // one quotient bit per cycle, most significant first
          rem_r <= remFits ? remShift - {1'b0, dvs_r} : remShift;
          dvd_r <= {dvd_r[DVD_W-2:0], remFits};
          divStep_r <= divStep_r + 5'd1;
          if (divStep_r == 5'(DVD_W - 1)) begin
            divState_r <= DIV_DONE;
          end
        end
        DIV_DONE: divState_r <= DIV_IDLE;
        default: divState_r <= DIV_IDLE;
      endcase
    end
  end

  // quotient saturates; a zero pulses-per-meter setting shows zero
  // the word keeps its last value while the next quotient is worked out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linSpeed_r <= MON_RESET;
    end else if (divState_r == DIV_DONE) begin
      if (dvs_r == 16'h0000) begin
        linSpeed_r <= MON_RESET;
      end else if (dvd_r > DVD_W'(U16_MAX)) begin
        linSpeed_r <= U16_MAX;
      end else begin
        linSpeed_r <= dvd_r[15:0];
      end
    end
  end

  // setting mirror takes host writes to the setting address, held to 100.00 percent
  // writes to any other address are dropped with no error indication
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mirror_r <= MON_RESET;
    end else if (hostWrEn && hostAddr == HOST_SET_ADDR) begin
      if ($signed(hostWrData) > PCT_MAX) begin
        mirror_r <= PCT_MAX;
      end else if ($signed(hostWrData) < -PCT_MAX) begin
        mirror_r <= -PCT_MAX;
      end else begin
        mirror_r <= hostWrData;
      end
    end
  end

  // next value of every word; unlisted words in the window read zero
  always_comb begin
    for (int i = 0; i < MON_WORDS; i++) begin
      monNxt[i] = MON_RESET;
    end
    monNxt[OFS_RUN_FREQ] = absClamp(runFreqRaw);
    monNxt[OFS_SET_FREQ] = absClamp(setFreqRaw);

    // quantities measured elsewhere pass straight through
    monNxt[OFS_BUS_VOLT] = busVoltage;
    monNxt[OFS_OUT_VOLT] = outputVoltage;
    monNxt[OFS_OUT_CURR] = outputCurrent;
    monNxt[OFS_OUT_POWER] = outputPower;
    monNxt[OFS_OUT_TORQUE] = outputTorque;

    // terminal bitmaps and the analog reading in its selected unit
    monNxt[OFS_IN_BITMAP] = inBits;
    monNxt[OFS_OUT_BITMAP] = outBits;
    monNxt[OFS_AN2_READING] = analogTwoUnitSelect ? analogTwoMilliamps : analogTwoVolts;
    monNxt[OFS_LOAD_SPEED] = loadSpeed;
    monNxt[OFS_LOOP_SET] = loopSetpoint;
    monNxt[OFS_LOOP_FB] = loopFeedback;

    // pulse and speed words; speed scaling follows the display setting
    monNxt[OFS_PULSE_KHZ] = pulseKhz;
    monNxt[OFS_FB_SPEED] = scaleSpeed(feedbackSpeedRaw, speedDigit);

    // the run-time word reads zero while the timer is stopped
    if (runTimerActive) begin
      monNxt[OFS_RUN_LEFT] = (runTimeLeft > RUN_LEFT_MAX) ? RUN_LEFT_MAX : runTimeLeft;
    end

    // raw samples; the linear correction is applied outside this block
    monNxt[OFS_AN1_RAW] = analogOneRaw;
    monNxt[OFS_AN2_RAW] = analogTwoRaw;
    monNxt[OFS_AN3_RAW] = analogThreeRaw;
    monNxt[OFS_LIN_SPEED] = linSpeed_r;
    monNxt[OFS_PULSE_HZ] = pulseHz;
    monNxt[OFS_HOST_MIRROR] = mirror_r;
    monNxt[OFS_ENC_SPEED] = scaleSpeed(encoderSpeedRaw, speedDigit);

    // remaining words are shown as delivered
    monNxt[OFS_MAIN_FREQ] = mainFrequency;
    monNxt[OFS_AUX_FREQ] = auxiliaryFrequency;
    monNxt[OFS_MOTOR_TEMP] = motorTemperature;
    monNxt[OFS_TARGET_TORQUE] = targetTorque;
    monNxt[OFS_ANGLE_POS] = angleSensorPosition;
    monNxt[OFS_PF_ANGLE] = powerFactorAngle;
    monNxt[OFS_QUAD_POS] = quadPos;
  end

  // every word refreshes each cycle, independent of host traffic
  // words with no quantity behind them stay at zero and read as such
  generate
    for (genvar g = 0; g < MON_WORDS; g++) begin : gWord
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mon_r[g] <= MON_RESET;
        end else begin
          mon_r[g] <= monNxt[g];
        end
      end
    end
  endgenerate

  // host read decode
  assign inWindow = (hostAddr >= MON_BASE) && (hostAddr <= MON_LAST);
  assign wordOfs = hostAddr - MON_BASE;

  // read answer one cycle later; a read only samples, never writes back
  // reads outside the window answer zero with the error flag, never a stale word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostRdData <= MON_RESET;
      hostRdValid <= 1'b0;
      hostAddrErr <= 1'b0;
    end else begin
      hostRdValid <= hostRdEn;
      hostAddrErr <= hostRdEn && !inWindow;
      if (hostRdEn) begin
        hostRdData <= inWindow ? mon_r[wordOfs[IDX_W-1:0]] : MON_RESET;
      end
    end
  end
endmodule : drive_monitor_readout_bank

/* File: verilog/quad_position_counter.sv */
`timescale 1ns/1ps
module quad_position_counter
  import drive_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic phaseA,
  input wire logic phaseB,
  output logic [15:0] position
);
  logic [1:0] prevAb_r;
  logic primed_r;
  logic [15:0] pos_r;
  logic [15:0] posNxt;

  // every edge of either phase counts, giving four counts per line
  always_comb begin
    posNxt = pos_r;
    case ({prevAb_r, phaseA, phaseB})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: posNxt = pos_r + 16'h0001;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: posNxt = pos_r - 16'h0001;
      default: posNxt = pos_r; // no move, or an illegal double step
    endcase
  end

  // 16-bit arithmetic wraps 65535 to 0 and 0 to 65535; the first cycle after reset
  // only learns the phase levels, so an encoder resting off 00 gives no false count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevAb_r <= 2'b00;
      primed_r <= 1'b0;
      pos_r <= MON_RESET;
    end else begin
      prevAb_r <= {phaseA, phaseB};
      primed_r <= 1'b1;
      pos_r <= primed_r ? posNxt : pos_r;
    end
  end

  assign position = pos_r;
endmodule : quad_position_counter
